// File: inc/plkb_params.svh
/*
 * Field positions, widths, register offsets and fixed values for the
 * policy lookup key builder.
 * Assumes it is included by its bare name after the package.
 */
`ifndef PLKB_PARAMS_SVH
`define PLKB_PARAMS_SVH

`define PLKB_KEY_W        188
`define PLKB_FIELD_LO     46
// Generic IPv4 key
`define PLKB_G_IPV4       46
`define PLKB_G_FRAG       47
`define PLKB_G_LATER      48
`define PLKB_G_OPTS       49
`define PLKB_G_HOPS       50
`define PLKB_G_TOS        51
`define PLKB_G_DST        59
`define PLKB_G_SRC        91
`define PLKB_G_EQ         123
`define PLKB_G_PROTO      124
`define PLKB_G_PAY        132
`define PLKB_G_TOP        187
// Standard IPv6 key
`define PLKB_S_HOPS       46
`define PLKB_S_SRC        47
`define PLKB_S_PROTO      175
`define PLKB_S_TOP        182
// Maintenance key
`define PLKB_O_DMAC       46
`define PLKB_O_SMAC       94
`define PLKB_O_LVL        142
`define PLKB_O_VER        149
`define PLKB_O_OPC        154
`define PLKB_O_FLG        162
`define PLKB_O_MEP        170
`define PLKB_O_LOSS0      186
`define PLKB_O_ETY        187
`define PLKB_O_TOP        187
// Widths
`define PLKB_W_BYTE       8
`define PLKB_W_IP4        32
`define PLKB_W_IP6        128
`define PLKB_W_PAY        56
`define PLKB_W_MAC        48
`define PLKB_W_LVL        7
`define PLKB_W_VER        5
`define PLKB_W_MEP        16
// Fixed values
`define PLKB_IHL_PLAIN    4'h5
`define PLKB_OAM_ETYPE    16'h8902
// Registers
`define PLKB_REG_CTRL     12'h000
`define PLKB_REG_STAT     12'h004
`define PLKB_CTRL_V6STD   0
`define PLKB_CTRL_ENABLE  1
`define PLKB_CTRL_RESET   32'h0000_0003
`define PLKB_STAT_TYPE    16

`endif

// File: inc/plkb_pkg.sv
/*
 * Types of the policy lookup key builder.
 * Assumes nothing of its surroundings.
 */
package plkb_pkg;

	typedef enum logic [3:0] {
		PLKB_KT_NONE = 4'h1,
		PLKB_KT_GEN  = 4'h2,
		PLKB_KT_V6   = 4'h4,
		PLKB_KT_OAM  = 4'h8
	} plkb_kt_e;

	typedef struct packed {
		logic         is_ipv4;
		logic         is_ipv6;
		logic         is_oam;
		logic         is_ccm;
		logic         more_frags;
		logic [12:0]  frag_ofs;
		logic [3:0]   ihl;
		logic [7:0]   ttl;
		logic [7:0]   tos;
		logic [31:0]  v4_src;
		logic [31:0]  v4_dst;
		logic [127:0] v6_src;
		logic [127:0] v6_dst;
		logic [7:0]   proto;
		logic [55:0]  payload;
		logic [47:0]  dmac;
		logic [47:0]  smac;
		logic [2:0]   level;
		logic [4:0]   maint_version_field;
		logic [7:0]   maint_opcode_field;
		logic [7:0]   maint_flags_field;
		logic [15:0]  mep_id;
		logic [31:0]  tx_fcf;
		logic [31:0]  rx_fcb;
		logic [31:0]  tx_fcb;
		logic [15:0]  ethertype;
	} plkb_hdr_s;

	typedef struct packed {
		logic [187:0] key;
		logic [187:0] care;
		plkb_kt_e     kind;
		logic         l4_dont_care;
	} plkb_key_s;

endpackage

// File: verilog/plkb_key_builder.sv
/*
 * Second-stage policy lookup key builder: generic IPv4, standard IPv6
 * and maintenance half-keys, each with a per-bit care mask, plus an
 * APB register pair.
 * Assumes the frame parser presents one header per hdr_valid pulse on
 * pclk, and that the matcher applies the care mask and fills bits 45:0.
 */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "plkb_params.svh"

module plkb_key_builder import plkb_pkg::*; (
	input  wire logic        pclk,         // Core clock, 20 MHz
	input  wire logic        presetn,      // Async reset, active low
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB access phase
	input  wire logic        pwrite,       // APB write
	input  wire logic [11:0] paddr,        // APB byte address
	input  wire logic [31:0] pwdata,       // APB write data
	input  wire logic [3:0]  pstrb,        // APB byte strobes
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error on unmapped address
	input  wire logic        hdr_valid,    // Parsed header pulse
	input  wire plkb_hdr_s   hdr,          // Parsed header fields
	output logic             key_valid,    // Key pulse, one cycle
	output plkb_key_s        key_out       // Key, care mask, kind
);

	////////////////////////////////////////////////////////////////////////
	// Registers over APB

	logic [31:0] ctrl_q;
	logic [15:0] count_q;
	plkb_key_s   key_q;
	logic        key_valid_q;

	wire         acc_w   = psel & penable;
	wire         hit_ctl = (paddr == `PLKB_REG_CTRL);
	wire         hit_st  = (paddr == `PLKB_REG_STAT);
	wire         wr_ctl  = acc_w & pwrite & hit_ctl;
	wire         v6std   = ctrl_q[`PLKB_CTRL_V6STD];
	wire         enable  = ctrl_q[`PLKB_CTRL_ENABLE];
	wire [31:0]  stat_w  = {12'h000, key_q.kind, count_q};

	assign pready  = 1'b1;
	assign pslverr = acc_w & ~hit_ctl & ~hit_st;
	assign prdata  = ~(acc_w & ~pwrite) ? 32'h0000_0000 :
	                 hit_ctl ? ctrl_q : hit_st ? stat_w : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PLKB_CTRL_RESET;
		end else if (wr_ctl) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					ctrl_q[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame classification

	wire       frag_w    = hdr.is_ipv4 & (hdr.more_frags | (hdr.frag_ofs != 13'h0000));
	wire       later_w   = hdr.is_ipv4 & (hdr.frag_ofs != 13'h0000);
	wire       opts_w    = hdr.is_ipv4 & (hdr.ihl > `PLKB_IHL_PLAIN);
	wire       l4dc_w    = opts_w | later_w;
	wire       hops_w    = (hdr.ttl != 8'h00);
	wire       eq_w      = hdr.is_ipv6 ? (hdr.v6_src == hdr.v6_dst)
	                                   : (hdr.v4_src == hdr.v4_dst);
	wire       loss0_w   = hdr.is_ccm & (hdr.tx_fcf == 32'h0) &
	                       (hdr.rx_fcb == 32'h0) & (hdr.tx_fcb == 32'h0);
	wire       ety_w     = (hdr.ethertype == `PLKB_OAM_ETYPE);
	wire [7:0] therm8_w  = (8'h01 << hdr.level) - 8'h01;
	wire [6:0] therm_w   = therm8_w[6:0];

	// Maintenance wins over IP; IPv6 falls back to generic when standard is off
	wire       use_oam   = hdr.is_oam;
	wire       use_v6    = ~use_oam & hdr.is_ipv6 & v6std;
	wire       use_gen   = ~use_oam & (hdr.is_ipv4 | (hdr.is_ipv6 & ~v6std));
	wire       take_w    = hdr_valid & enable & (use_oam | use_v6 | use_gen);
	plkb_kt_e  kind_w;
	assign kind_w = use_oam ? PLKB_KT_OAM : use_v6 ? PLKB_KT_V6 :
	                use_gen ? PLKB_KT_GEN : PLKB_KT_NONE;

	////////////////////////////////////////////////////////////////////////
	// Key assembly

	logic [`PLKB_KEY_W-1:0] gen_k, gen_c, v6_k, v6_c, oam_k, oam_c;

	always_comb begin
		gen_k = '0;
		gen_c = '0;
		gen_k[`PLKB_G_IPV4]  = hdr.is_ipv4;
		gen_k[`PLKB_G_FRAG]  = frag_w;
		gen_k[`PLKB_G_LATER] = later_w;
		gen_k[`PLKB_G_OPTS]  = opts_w;
		gen_k[`PLKB_G_HOPS]  = hops_w;
		gen_k[`PLKB_G_TOS +: `PLKB_W_BYTE] = hdr.tos;
		gen_k[`PLKB_G_DST +: `PLKB_W_IP4]  = hdr.is_ipv6 ? hdr.v6_src[63:32] : hdr.v4_dst;
		gen_k[`PLKB_G_SRC +: `PLKB_W_IP4]  = hdr.is_ipv6 ? hdr.v6_src[31:0] : hdr.v4_src;
		gen_k[`PLKB_G_EQ]    = eq_w;
		gen_k[`PLKB_G_PROTO +: `PLKB_W_BYTE] = hdr.proto;
		// Options are not skipped, so option bytes land here
		gen_k[`PLKB_G_PAY +: `PLKB_W_PAY] = hdr.payload;
		gen_c[`PLKB_G_TOP:`PLKB_FIELD_LO] = '1;
	end

	always_comb begin
		v6_k = '0;
		v6_c = '0;
		v6_k[`PLKB_S_HOPS] = hops_w;
		v6_k[`PLKB_S_SRC +: `PLKB_W_IP6]    = hdr.v6_src;
		v6_k[`PLKB_S_PROTO +: `PLKB_W_BYTE] = hdr.proto;
		v6_c[`PLKB_S_TOP:`PLKB_FIELD_LO] = '1;
	end

	always_comb begin
		oam_k = '0;
		oam_c = '0;
		oam_k[`PLKB_O_DMAC +: `PLKB_W_MAC]  = hdr.dmac;
		oam_k[`PLKB_O_SMAC +: `PLKB_W_MAC]  = hdr.smac;
		oam_k[`PLKB_O_LVL +: `PLKB_W_LVL]   = therm_w;
		oam_k[`PLKB_O_VER +: `PLKB_W_VER]   = hdr.maint_version_field;
		oam_k[`PLKB_O_OPC +: `PLKB_W_BYTE]  = hdr.maint_opcode_field;
		oam_k[`PLKB_O_FLG +: `PLKB_W_BYTE]  = hdr.maint_flags_field;
		oam_k[`PLKB_O_MEP +: `PLKB_W_MEP]   = hdr.is_ccm ? hdr.mep_id : 16'h0000;
		oam_k[`PLKB_O_LOSS0] = loss0_w;
		oam_k[`PLKB_O_ETY]   = ety_w;
		oam_c[`PLKB_O_TOP:`PLKB_FIELD_LO] = '1;
		// Endpoint id has no meaning outside continuity checks
		oam_c[`PLKB_O_MEP +: `PLKB_W_MEP] = {`PLKB_W_MEP{hdr.is_ccm}};
	end

	wire [`PLKB_KEY_W-1:0] sel_k = use_oam ? oam_k : use_v6 ? v6_k : gen_k;
	wire [`PLKB_KEY_W-1:0] sel_c = use_oam ? oam_c : use_v6 ? v6_c : gen_c;

	////////////////////////////////////////////////////////////////////////
	// Output stage, one cycle after the header

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_q       <= '{key: '0, care: '0, kind: PLKB_KT_NONE, l4_dont_care: 1'b0};
			key_valid_q <= 1'b0;
		end else begin
			key_valid_q <= take_w;
			if (take_w) begin
				key_q.key          <= sel_k;
				key_q.care         <= sel_c;
				key_q.kind         <= kind_w;
				key_q.l4_dont_care <= use_gen & l4dc_w;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 16'h0000;
		end else if (take_w) begin
			count_q <= count_q + 16'h0001;
		end
	end

	assign key_valid = key_valid_q;
	assign key_out   = key_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_L4DC: assert property (take_w && use_gen && (opts_w || later_w) |=> key_out.l4_dont_care)
		else $error("Layer-4 don't-care not raised");
	AST_IPV4: assert property (take_w && use_gen |=> key_out.key[`PLKB_G_IPV4] == $past(hdr.is_ipv4))
		else $error("IPv4 indicator wrong");
	AST_V6FALL: assert property (take_w && hdr.is_ipv6 && !hdr.is_oam && !v6std |=> key_out.kind == PLKB_KT_GEN)
		else $error("IPv6 did not use generic key");
	AST_FRAG: assert property (key_valid && key_out.kind == PLKB_KT_GEN |-> key_out.key[`PLKB_G_FRAG] == $past(frag_w))
		else $error("Fragment flag wrong");
	AST_LATER: assert property (key_valid && key_out.kind == PLKB_KT_GEN && key_out.key[`PLKB_G_LATER]
		|-> key_out.key[`PLKB_G_FRAG])
		else $error("Later fragment without fragment flag");
	AST_OPTS: assert property (take_w && use_gen |=> key_out.key[`PLKB_G_OPTS] == $past(opts_w))
		else $error("Options flag wrong");
	AST_HOPS: assert property (take_w && use_v6 |=> key_out.key[`PLKB_S_HOPS] == ($past(hdr.ttl) != 8'h00))
		else $error("Hop limit flag wrong");
	AST_EQ: assert property (take_w && use_gen |=> key_out.key[`PLKB_G_EQ] == $past(eq_w))
		else $error("Address equal flag wrong");
	AST_DST: assert property (take_w && use_gen && hdr.is_ipv6 |=>
		key_out.key[`PLKB_G_DST +: `PLKB_W_IP4] == $past(hdr.v6_src[63:32]))
		else $error("IPv6 upper source bits misplaced");
	AST_THERM: assert property (key_valid && key_out.kind == PLKB_KT_OAM |->
		key_out.key[`PLKB_O_LVL +: `PLKB_W_LVL] == $past(therm_w))
		else $error("Level thermometer wrong");
	AST_ETY: assert property (take_w && use_oam |=> key_out.key[`PLKB_O_ETY] == ($past(hdr.ethertype) == `PLKB_OAM_ETYPE))
		else $error("EtherType flag wrong");
	AST_LOSS: assert property (take_w && use_oam && !hdr.is_ccm |=> !key_out.key[`PLKB_O_LOSS0])
		else $error("Loss flag on non-CCM frame");
	AST_CARE: assert property (key_valid |-> key_out.care[`PLKB_FIELD_LO-1:0] == '0 && key_out.care[`PLKB_FIELD_LO])
		else $error("Care mask span wrong");
	AST_PULSE: assert property (hdr_valid && !enable |=> !key_valid)
		else $error("Key emitted while disabled");

	COV_GEN_FRAG: cover property (take_w && use_gen && later_w);
	COV_V6STD:    cover property (take_w && use_v6);
	COV_OAM_CCM:  cover property (take_w && use_oam && loss0_w);
	COV_BACK2:    cover property (take_w ##1 take_w);

endmodule

// File: test/plkb_parser_model.sv
/*
 * Frame parser stand-in: presents one parsed header per call of send.
 * Assumes pclk is the core clock of the key builder it feeds.
 */
`timescale 1ns/10ps

module plkb_parser_model import plkb_pkg::*; (
	output logic      hdr_valid, // Header pulse
	output plkb_hdr_s hdr,       // Header fields
	input  wire logic pclk       // Core clock
);
	initial begin
		hdr_valid = 1'b0;
		hdr = '0;
	end

	////////////////////////////////////////////////////////////////
	// Fields are stale after the pulse, so show their inverse
	task automatic send(input plkb_hdr_s h);
		@(posedge pclk);
		hdr_valid <= 1'b1;
		hdr <= h;
		@(posedge pclk);
		hdr_valid <= 1'b0;
		hdr <= ~h;
	endtask
endmodule

// File: test/test_policy_lookup_key_builder.sv
/*
 * Self-checking bench of the policy lookup key builder: APB register
 * checks and header-to-key checks for all three key kinds.
 * Assumes the parser model beside it and a zero-wait APB slave.
 */
`timescale 1ns/10ps
`include "plkb_params.svh"

module test_policy_lookup_key_builder import plkb_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        pready, pslverr, hdr_valid, key_valid, v6s;
	plkb_hdr_s   hdr, h;
	plkb_key_s   key_out, z;
	int          n_fail, checked, n_keys;

	plkb_key_builder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hdr_valid(hdr_valid), .hdr(hdr), .key_valid(key_valid), .key_out(key_out));
	plkb_parser_model pm (.hdr_valid(hdr_valid), .hdr(hdr), .pclk(pclk));

	always #25 pclk = ~pclk;

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input logic [380:0] got, input logic [380:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic experr);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			conclude();
		end
		if (!wr) cmp(prdata, exp, "read data");
		cmp(pslverr, experr, "slave error");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	function automatic plkb_key_s exp_of(input plkb_hdr_s x);
		plkb_key_s e;
		e = '0;
		if (x.is_oam) begin
			e.kind = PLKB_KT_OAM;
			e.care[187:46] = '1;
			e.key[93:46] = x.dmac;
			e.key[141:94] = x.smac;
			e.key[148:142] = 7'((8'h1 << x.level) - 8'h1);
			e.key[153:149] = x.maint_version_field;
			e.key[161:154] = x.maint_opcode_field;
			e.key[169:162] = x.maint_flags_field;
			if (x.is_ccm) e.key[185:170] = x.mep_id;
			else e.care[185:170] = '0;
			e.key[186] = x.is_ccm && ({x.tx_fcf, x.rx_fcb, x.tx_fcb} == 96'h0);
			e.key[187] = (x.ethertype == 16'h8902);
		end else if (x.is_ipv6 && v6s) begin
			e.kind = PLKB_KT_V6;
			e.care[182:46] = '1;
			e.key[46] = (x.ttl != 8'h0);
			e.key[174:47] = x.v6_src;
			e.key[182:175] = x.proto;
		end else begin
			e.kind = PLKB_KT_GEN;
			e.care[187:46] = '1;
			e.key[46] = x.is_ipv4;
			e.key[50] = (x.ttl != 8'h0);
			e.key[58:51] = x.tos;
			e.key[131:124] = x.proto;
			e.key[187:132] = x.payload;
			if (x.is_ipv4) begin
				e.key[47] = x.more_frags || (x.frag_ofs != 13'h0);
				e.key[48] = (x.frag_ofs != 13'h0);
				e.key[49] = (x.ihl > 4'h5);
				e.key[90:59] = x.v4_dst;
				e.key[122:91] = x.v4_src;
				e.key[123] = (x.v4_src == x.v4_dst);
				e.l4_dont_care = (x.ihl > 4'h5) || (x.frag_ofs != 13'h0);
			end else begin
				e.key[90:59] = x.v6_src[63:32];
				e.key[122:91] = x.v6_src[31:0];
				e.key[123] = (x.v6_src == x.v6_dst);
			end
		end
		return e;
	endfunction

	// Key pulse lands one edge after the header edge and lasts one cycle
	task automatic frame(input logic take);
		plkb_key_s e;
		e = exp_of(h);
		pm.send(h);
		#1;
		cmp(key_valid, take, "key valid");
		if (take) cmp(key_out, e, "key out");
		if (take) n_keys++;
		@(posedge pclk);
		#1;
		cmp(key_valid, 1'b0, "key pulse end");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		{n_fail, checked, n_keys} = '0;
		v6s = 1'b1;
		z = '0;
		z.kind = PLKB_KT_NONE;
		repeat (16) @(posedge pclk);
		cmp(key_out, z, "reset key");
		presetn <= 1'b1;
		apb(1'b0, `PLKB_REG_CTRL, 32'h0, 32'h3, 1'b0);
		// No key yet: count zero, last kind reads as the none code
		apb(1'b0, `PLKB_REG_STAT, 32'h0, {12'h0, PLKB_KT_NONE, 16'h0}, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h010, 32'hffff_ffff, 32'h0, 1'b1);
		h = '0;
		h.is_ipv4 = 1'b1;
		h.ihl = 4'h5;
		h.ttl = 8'h40;
		h.tos = 8'hb8;
		h.v4_src = 32'hc0a8_0001;
		h.v4_dst = 32'h0a00_0002;
		h.v6_src = {4{32'h5a5a_c3c3}};
		h.proto = 8'h11;
		h.payload = 56'h0102_0304_0506_07;
		frame(1'b1);
		h.ihl = 4'h6;
		frame(1'b1);
		h.ihl = 4'h5;
		h.more_frags = 1'b1;
		frame(1'b1);
		h.frag_ofs = 13'h1;
		frame(1'b1);
		{h.more_frags, h.frag_ofs, h.ttl} = '0;
		h.v4_dst = h.v4_src;
		frame(1'b1);
		h.is_ipv4 = 1'b0;
		h.is_ipv6 = 1'b1;
		h.ttl = 8'h1;
		h.v6_dst = h.v6_src;
		frame(1'b1);
		apb(1'b1, `PLKB_REG_CTRL, 32'h2, 32'h0, 1'b0);
		v6s = 1'b0;
		frame(1'b1);
		h.v6_dst[127] = ~h.v6_dst[127];
		frame(1'b1);
		apb(1'b1, `PLKB_REG_CTRL, 32'h0, 32'h0, 1'b0);
		frame(1'b0);
		apb(1'b1, `PLKB_REG_CTRL, 32'h3, 32'h0, 1'b0);
		v6s = 1'b1;
		h.is_ipv6 = 1'b0;
		frame(1'b0);
		h.is_oam = 1'b1;
		h.is_ccm = 1'b1;
		h.dmac = 48'h0180_c200_0030;
		h.smac = 48'h0200_1122_3344;
		h.maint_version_field = 5'h1f;
		h.maint_opcode_field = 8'h01;
		h.maint_flags_field = 8'h84;
		h.mep_id = 16'h1abc;
		h.ethertype = 16'h8902;
		for (int l = 0; l < 8; l++) begin
			h.level = 3'(l);
			frame(1'b1);
		end
		h.tx_fcb = 32'h1;
		frame(1'b1);
		h.is_ccm = 1'b0;
		h.ethertype = 16'h8809;
		frame(1'b1);
		apb(1'b0, `PLKB_REG_STAT, 32'h0, {12'h0, 4'h8, 16'(n_keys)}, 1'b0);
		conclude();
	end
endmodule
